// ==== iec_pkg.sv ====
// constants and carrier types for the interprocessor event channel unit
// assumes a single core clock domain and a simple strobe register port
package iec_pkg;
  localparam int NumTasks = 8;
  localparam int NumChans = 8;
  localparam int NumScratch = 4;

  // register map (byte offsets, word per index)
  localparam logic [11:0] OffSendTrigger = 12'h000;
  localparam logic [11:0] OffSendSubscribe = 12'h080;
  localparam logic [11:0] OffRecvFlag = 12'h100;
  localparam logic [11:0] OffRecvPublish = 12'h180;
  localparam logic [11:0] OffIrqEnable = 12'h300;
  localparam logic [11:0] OffIrqEnableSet = 12'h304;
  localparam logic [11:0] OffIrqEnableClr = 12'h308;
  localparam logic [11:0] OffIrqPending = 12'h30C;
  localparam logic [11:0] OffSendMask = 12'h510;
  localparam logic [11:0] OffRecvMask = 12'h590;
  localparam logic [11:0] OffScratch = 12'h610;

  // subscribe / publish field layout
  localparam int ChanIdxLsb = 0;
  localparam int ChanIdxW = 8;
  localparam int ChanEnBit = 31;

  localparam logic [31:0] RstWord = 32'h0000_0000;
  localparam logic [7:0] RstByte = 8'h00;

  // merge window on the shared channels, in ns, and as cycles
  localparam int ClkPeriodNs = 20;
  localparam int MergeWindowNs = 165000;
  localparam int MergeWindowCycles = MergeWindowNs / ClkPeriodNs;

  typedef struct packed {
    logic en;
    logic [ChanIdxW-1:0] idx;
  } iec_route_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iec_bus_req_t;

  typedef struct packed {
    iec_route_t [NumTasks-1:0] subscribe;
    iec_route_t [NumTasks-1:0] publish;
    logic [NumTasks-1:0] recvFlag;
    logic [NumTasks-1:0] irqEn;
    logic [NumTasks-1:0][NumChans-1:0] sendMask;
    logic [NumTasks-1:0][NumChans-1:0] recvMask;
    logic [NumScratch-1:0][31:0] scratch;
    logic [NumChans-1:0] chanOut;
    logic [NumChans-1:0] chanSync1;
    logic [NumChans-1:0] chanSync2;
    logic [NumChans-1:0] chanPrev;
    logic [255:0] fabricOut;
    logic [31:0] rdata;
    logic irq;
  } iec_state_t;
endpackage : iec_pkg

// ==== iec_event_unit.sv ====
// interprocessor event channel unit: send tasks, receive events, irq, scratch
// assumes shared channels are wired-or of all instances, one unit per
// processor, and 256 fabric lines pulsing one core cycle per event
module iec_event_unit
  import iec_pkg::*;
(
  input wire logic core_clk, // 50 MHz core clock
  input wire logic resetn, // async reset, active low
  input wire iec_bus_req_t busReq, // register port request
  output logic [31:0] busRdata, // read data, cycle after read strobe
  input wire logic [NumChans-1:0] chanIn, // shared channels, wired-or of peers
  output logic [NumChans-1:0] chanOut, // this unit's channel pulses
  input wire logic [255:0] fabricIn, // event interconnect lines
  output logic [255:0] fabricOut, // event interconnect publish pulses
  output logic irq // interrupt request
);
  iec_state_t s_q, s_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base,
                               input int n, input int k);
    return a == base + 12'(4 * k) && k < n;
  endfunction : hit

  function automatic logic [31:0] routeWord(input iec_route_t r);
    logic [31:0] w;
    w = RstWord;
    w[ChanEnBit] = r.en;
    w[ChanIdxLsb +: ChanIdxW] = r.idx;
    return w;
  endfunction : routeWord

  logic [NumTasks-1:0] sendFire;
  logic [NumChans-1:0] chanRise;
  logic [NumTasks-1:0] recvFire;

  always_comb begin
    s_d = s_q;
    sendFire = '0;
    recvFire = '0;
    // second stage only feeds edge detect; first stage feeds nothing else
    s_d.chanSync1 = chanIn;
    s_d.chanSync2 = s_q.chanSync1;
    s_d.chanPrev = s_q.chanSync2;
    chanRise = s_q.chanSync2 & ~s_q.chanPrev;
    for (int n = 0; n < NumTasks; n++) begin
      if (busReq.wr && hit(busReq.addr, OffSendTrigger, NumTasks, n)
          && busReq.wdata[0]) begin
        sendFire[n] = 1'b1;
      end
      if (s_q.subscribe[n].en && fabricIn[s_q.subscribe[n].idx]) begin
        sendFire[n] = 1'b1;
      end
      recvFire[n] = |(chanRise & s_q.recvMask[n]);
    end
    s_d.chanOut = '0;
    for (int n = 0; n < NumTasks; n++) begin
      if (sendFire[n]) begin
        s_d.chanOut = s_d.chanOut | s_q.sendMask[n];
      end
    end
    s_d.fabricOut = '0;
    for (int n = 0; n < NumTasks; n++) begin
      if (recvFire[n] && s_q.publish[n].en) begin
        s_d.fabricOut[s_q.publish[n].idx] = 1'b1;
      end
    end
    if (busReq.wr) begin
      for (int n = 0; n < NumTasks; n++) begin
        if (hit(busReq.addr, OffSendSubscribe, NumTasks, n)) begin
          s_d.subscribe[n].en = busReq.wdata[ChanEnBit];
          s_d.subscribe[n].idx = busReq.wdata[ChanIdxLsb +: ChanIdxW];
        end
        if (hit(busReq.addr, OffRecvPublish, NumTasks, n)) begin
          s_d.publish[n].en = busReq.wdata[ChanEnBit];
          s_d.publish[n].idx = busReq.wdata[ChanIdxLsb +: ChanIdxW];
        end
        if (hit(busReq.addr, OffRecvFlag, NumTasks, n)) begin
          s_d.recvFlag[n] = busReq.wdata[0];
        end
        if (hit(busReq.addr, OffSendMask, NumTasks, n)) begin
          s_d.sendMask[n] = busReq.wdata[NumChans-1:0];
        end
        if (hit(busReq.addr, OffRecvMask, NumTasks, n)) begin
          s_d.recvMask[n] = busReq.wdata[NumChans-1:0];
        end
      end
      for (int k = 0; k < NumScratch; k++) begin
        if (hit(busReq.addr, OffScratch, NumScratch, k)) begin
          s_d.scratch[k] = busReq.wdata;
        end
      end
      if (busReq.addr == OffIrqEnable) begin
        s_d.irqEn = busReq.wdata[NumTasks-1:0];
      end
      if (busReq.addr == OffIrqEnableSet) begin
        s_d.irqEn = s_q.irqEn | busReq.wdata[NumTasks-1:0];
      end
      if (busReq.addr == OffIrqEnableClr) begin
        s_d.irqEn = s_q.irqEn & ~busReq.wdata[NumTasks-1:0];
      end
    end
    // a hardware event wins over a software clear in the same cycle
    s_d.recvFlag = s_d.recvFlag | recvFire;
    s_d.irq = |(s_d.recvFlag & s_d.irqEn);
    s_d.rdata = RstWord;
    if (busReq.rd) begin
      for (int n = 0; n < NumTasks; n++) begin
        if (hit(busReq.addr, OffSendSubscribe, NumTasks, n)) begin
          s_d.rdata = routeWord(s_q.subscribe[n]);
        end
        if (hit(busReq.addr, OffRecvPublish, NumTasks, n)) begin
          s_d.rdata = routeWord(s_q.publish[n]);
        end
        if (hit(busReq.addr, OffRecvFlag, NumTasks, n)) begin
          s_d.rdata = {31'h0000_0000, s_q.recvFlag[n]};
        end
        if (hit(busReq.addr, OffSendMask, NumTasks, n)) begin
          s_d.rdata = {24'h00_0000, s_q.sendMask[n]};
        end
        if (hit(busReq.addr, OffRecvMask, NumTasks, n)) begin
          s_d.rdata = {24'h00_0000, s_q.recvMask[n]};
        end
      end
      for (int k = 0; k < NumScratch; k++) begin
        if (hit(busReq.addr, OffScratch, NumScratch, k)) begin
          s_d.rdata = s_q.scratch[k];
        end
      end
      if (busReq.addr == OffIrqEnable || busReq.addr == OffIrqEnableSet
          || busReq.addr == OffIrqEnableClr) begin
        s_d.rdata = {24'h00_0000, s_q.irqEn};
      end
      if (busReq.addr == OffIrqPending) begin
        s_d.rdata = {24'h00_0000, s_q.recvFlag & s_q.irqEn};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a register so peers never see combinational glitches
  assign busRdata = s_q.rdata;
  assign chanOut = s_q.chanOut; // this unit's own drive onto the shared set
  assign fabricOut = s_q.fabricOut;
  assign irq = s_q.irq;

  // assertion helpers
  logic [7:0] trigWr;
  always_comb begin
    trigWr = '0;
    for (int n = 0; n < NumTasks; n++) begin
      trigWr[n] = busReq.wr && busReq.wdata[0]
                  && hit(busReq.addr, OffSendTrigger, NumTasks, n);
    end
  end

  // union of every send mask: the widest pattern any send can reach
  logic [NumChans-1:0] sendUnion;
  always_comb begin
    sendUnion = '0;
    for (int n = 0; n < NumTasks; n++) begin
      sendUnion = sendUnion | s_q.sendMask[n];
    end
  end

  // rising edge seen on channel 3 after the two sync stages
  sequence chanEdge3;
    s_q.chanSync2[3] && !s_q.chanPrev[3];
  endsequence

  // register port steps, one strobe cycle each
  sequence regWrite(logic [11:0] a);
    busReq.wr && busReq.addr == a;
  endsequence

  sequence regRead(logic [11:0] a);
    busReq.rd && busReq.addr == a;
  endsequence

  // a fabric line that subscriber 1 listens to fires this cycle
  sequence subHit1;
    s_q.subscribe[1].en && fabricIn[s_q.subscribe[1].idx];
  endsequence

  a_trig_chan_out: assert property (@(posedge core_clk) disable iff (!resetn)
    trigWr[0] |=> (chanOut & s_q.sendMask[0]) == $past(s_q.sendMask[0]))
    else $error("send task 0 did not pulse its channels");
  a_no_stray_out: assert property (@(posedge core_clk) disable iff (!resetn)
    (trigWr == 8'h00 && s_q.subscribe[0].en == 1'b0 && busReq.wr == 1'b0
     && s_q.sendMask == '0) |=> chanOut == 8'h00)
    else $error("channel pulse without a send task");
  a_recv_flag_set: assert property (@(posedge core_clk) disable iff (!resetn)
    (chanEdge3 and s_q.recvMask[2][3]) |=> s_q.recvFlag[2])
    else $error("receive event 2 missed a channel pulse");
  a_chan_sync_lat: assert property (@(posedge core_clk) disable iff (!resetn)
    ($rose(chanIn[3]) ##1 chanIn[3] ##1 chanIn[3]) |-> s_q.chanSync2[3])
    else $error("channel input not seen after two stages");
  a_irq_pending: assert property (@(posedge core_clk) disable iff (!resetn)
    irq == |(s_q.recvFlag & s_q.irqEn))
    else $error("irq does not follow pending bits");
  a_enable_set: assert property (@(posedge core_clk) disable iff (!resetn)
    (busReq.wr && busReq.addr == OffIrqEnableSet) |=> (s_q.irqEn & $past(busReq.wdata[7:0]))
      == $past(busReq.wdata[7:0]))
    else $error("enable set write did not enable");
  a_enable_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (busReq.wr && busReq.addr == OffIrqEnableClr) |=> (s_q.irqEn & $past(busReq.wdata[7:0]))
      == 8'h00)
    else $error("enable clear write did not disable");
  a_pending_read: assert property (@(posedge core_clk) disable iff (!resetn)
    (busReq.rd && busReq.addr == OffIrqPending) |=> busRdata[7:0]
      == $past(s_q.recvFlag & s_q.irqEn))
    else $error("pending read wrong");
  a_scratch_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    (busReq.wr && busReq.addr == OffScratch) ##1 (busReq.rd && busReq.addr == OffScratch
      && !busReq.wr) |=> busRdata == $past(busReq.wdata, 2))
    else $error("scratch word lost its value");
  a_publish_out: assert property (@(posedge core_clk) disable iff (!resetn)
    (recvFire[2] && s_q.publish[2].en) |=> fabricOut[$past(s_q.publish[2].idx)])
    else $error("publish line not pulsed");

  // sends: pulses stay inside the masks, several sends merge by or
  a_quiet_no_mask: assert property (@(posedge core_clk) disable iff (!resetn)
    (sendUnion == 8'h00) |=> chanOut == 8'h00)
    else $error("channel pulse with every send mask empty");
  a_out_in_union: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1 |=> (chanOut & ~$past(sendUnion)) == 8'h00)
    else $error("channel pulsed outside every send mask");
  a_sub_fires: assert property (@(posedge core_clk) disable iff (!resetn)
    subHit1 |=> (chanOut & $past(s_q.sendMask[1])) == $past(s_q.sendMask[1]))
    else $error("subscribed fabric line did not fire send task 1");

  // receive side: a held level is one event, a software clear loses to hardware
  a_held_no_event: assert property (@(posedge core_clk) disable iff (!resetn)
    (!busReq.wr && (s_q.chanSync2 & ~s_q.chanPrev) == 8'h00) |=> s_q.recvFlag == $past(s_q.recvFlag))
    else $error("event flag moved without a channel edge");
  a_event_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    (chanEdge3 and (s_q.recvMask[2][3] && s_q.irqEn[2] && !busReq.wr)) |=> irq)
    else $error("enabled receive event did not raise irq");
  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.recvFlag[2] && !busReq.wr) |=> s_q.recvFlag[2])
    else $error("event flag dropped without a write");
  a_flag_sw_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (regWrite(OffRecvFlag + 12'h008) and (!busReq.wdata[0] && !recvFire[2])) |=> !s_q.recvFlag[2])
    else $error("writing 0 did not clear event flag");
  a_flag_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffRecvFlag + 12'h008) |=> busRdata == {31'h0000_0000, $past(s_q.recvFlag[2])})
    else $error("event flag read wrong");

  // enable register and its set and clear views
  a_enable_write: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffIrqEnable) |=> s_q.irqEn == $past(busReq.wdata[7:0]))
    else $error("enable write not stored");
  a_enable_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffIrqEnable) |=> busRdata == {24'h00_0000, $past(s_q.irqEn)})
    else $error("enable read wrong");
  a_set_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffIrqEnableSet) |=> (s_q.irqEn & $past(s_q.irqEn)) == $past(s_q.irqEn))
    else $error("enable set write cleared a bit");
  a_clear_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffIrqEnableClr) |=> busRdata == {24'h00_0000, $past(s_q.irqEn)})
    else $error("enable clear view read wrong");
  a_clr_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffIrqEnableClr) |=> (s_q.irqEn & ~$past(busReq.wdata[7:0]))
      == ($past(s_q.irqEn) & ~$past(busReq.wdata[7:0])))
    else $error("enable clear write touched a zero bit");
  a_pend_masked: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffIrqPending) |=> (busRdata[7:0] & ~$past(s_q.irqEn)) == 8'h00)
    else $error("pending shows a disabled event");

  // configuration words read back as written; the trigger word reads zero
  a_trig_reads_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffSendTrigger) |=> busRdata == 32'h0000_0000)
    else $error("trigger word read not zero");
  a_mask_write: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffSendMask) |=> s_q.sendMask[0] == $past(busReq.wdata[7:0]))
    else $error("send mask write not stored");
  a_mask_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffSendMask) |=> busRdata == {24'h00_0000, $past(s_q.sendMask[0])})
    else $error("send mask read wrong");
  a_rmask_write: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffRecvMask + 12'h008) |=> s_q.recvMask[2] == $past(busReq.wdata[7:0]))
    else $error("receive mask write not stored");
  a_rmask_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffRecvMask) |=> busRdata == {24'h00_0000, $past(s_q.recvMask[0])})
    else $error("receive mask read wrong");
  a_scratch_write: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffScratch + 12'h00C) |=> s_q.scratch[3] == $past(busReq.wdata))
    else $error("scratch write not stored");
  a_scratch_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffScratch + 12'h00C) |=> busRdata == $past(s_q.scratch[3]))
    else $error("scratch read wrong");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    !busReq.rd |=> busRdata == 32'h0000_0000)
    else $error("read data stands without a read");

  // fabric routes
  a_sub_write: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffSendSubscribe + 12'h004) |=> s_q.subscribe[1].en == $past(busReq.wdata[31])
      && s_q.subscribe[1].idx == $past(busReq.wdata[7:0]))
    else $error("subscribe write not stored");
  a_sub_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffSendSubscribe + 12'h004) |=> busRdata == {$past(s_q.subscribe[1].en),
      23'h00_0000, $past(s_q.subscribe[1].idx)})
    else $error("subscribe read wrong");
  a_pub_write: assert property (@(posedge core_clk) disable iff (!resetn)
    regWrite(OffRecvPublish + 12'h008) |=> s_q.publish[2].en == $past(busReq.wdata[31])
      && s_q.publish[2].idx == $past(busReq.wdata[7:0]))
    else $error("publish write not stored");
  a_pub_read: assert property (@(posedge core_clk) disable iff (!resetn)
    regRead(OffRecvPublish + 12'h008) |=> busRdata == {$past(s_q.publish[2].en),
      23'h00_0000, $past(s_q.publish[2].idx)})
    else $error("publish read wrong");
  a_pub_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_q.publish == '0) |=> fabricOut == '0)
    else $error("fabric pulse with publishing off");
endmodule : iec_event_unit

// ==== iec_peer_model.sv ====
// peer unit on the shared channels: pulses channels and logs this unit's pulses
// assumes the bench orders each pulse and feeds this drive straight to the unit's channel inputs
module iec_peer_model
  import iec_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic fire, // start one pulse
  input wire logic [NumChans-1:0] fireMask, // channels to pulse
  input wire logic [NumChans-1:0] chanSeen, // pulses of the unit under test
  output logic [NumChans-1:0] chanDrive, // this peer's channel drive
  output logic [NumChans-1:0] heard, // channels seen pulsing
  output logic [7:0] pulseCycles // cycles with any pulse seen
);
  logic [1:0] hold;

  // a released channel returns to idle low, the wired-or rest level
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chanDrive <= '0;
      hold <= 2'h0;
      heard <= '0;
      pulseCycles <= 8'h00;
    end else begin
      // three cycles high so the two-flop sync sees it; one pulse per channel per run
      if (fire) begin
        chanDrive <= fireMask;
        hold <= 2'h2;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end else begin
        chanDrive <= '0;
      end
      heard <= heard | chanSeen;
      if (chanSeen != '0) begin
        pulseCycles <= pulseCycles + 8'h01;
      end
    end
  end
endmodule : iec_peer_model

// ==== test_interprocessor_event_channels.sv ====
// self-checking bench for the interprocessor event channel unit
// assumes one peer model on the channels; the fabric lines are driven here
module test_interprocessor_event_channels
  import iec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  iec_bus_req_t req = '0;
  logic [255:0] fabricIn = '0;
  logic fire = 1'b0;
  logic [7:0] fireMask = 8'h00;
  logic [31:0] busRdata, d;
  logic [7:0] chanOut, chanDrive, heard, pulseCycles;
  logic [255:0] fabricOut;
  logic irq;
  int fails = 0;
  int compares = 0;

  always #10 core_clk = ~core_clk;

  iec_event_unit dut (.core_clk(core_clk), .resetn(resetn), .busReq(req),
    .busRdata(busRdata), .chanIn(chanDrive), .chanOut(chanOut), .fabricIn(fabricIn),
    .fabricOut(fabricOut), .irq(irq));
  iec_peer_model peer (.core_clk(core_clk), .resetn(resetn), .fire(fire),
    .fireMask(fireMask), .chanSeen(chanOut), .chanDrive(chanDrive), .heard(heard),
    .pulseCycles(pulseCycles));

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge core_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic chkRd(input string nm, input logic [11:0] a, input logic [31:0] ex);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    d = busRdata;
    `CHK(nm, ex, d)
  endtask : chkRd

  task automatic regTask();
    logic [11:0] offs[8] = '{12'h080, 12'h100, 12'h180, 12'h300, 12'h30C, 12'h510,
      12'h590, 12'h610};
    foreach (offs[k]) chkRd("reset value", offs[k], 32'h0);
    wr(OffScratch + 12'h00C, 32'hA5C3_0F96);
    chkRd("scratch", OffScratch + 12'h00C, 32'hA5C3_0F96);
    chkRd("trigger word", OffSendTrigger, 32'h0);
    chkRd("unmapped", 12'h7F0, 32'h0);
  endtask : regTask

  task automatic sendTask();
    wr(OffSendMask, 32'h05);
    wr(OffSendTrigger + 12'h004, 32'h1);
    wr(OffSendTrigger, 32'h1);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("channels heard", 8'h05, heard)
    `CHK("pulse cycles", 8'h01, pulseCycles)
  endtask : sendTask

  task automatic recvTask();
    int i;
    wr(OffRecvMask + 12'h008, 32'h08);
    wr(OffRecvPublish + 12'h008, 32'h8000_0009);
    wr(OffIrqEnableSet, 32'h04);
    chkRd("irq enable", OffIrqEnable, 32'h04);
    @(posedge core_clk);
    fireMask <= 8'h08;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    for (i = 0; i < 12 && fabricOut[9] !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK("publish pulse", 1'b1, fabricOut[9])
    @(posedge core_clk);
    #1;
    `CHK("publish end", 256'h0, fabricOut)
    chkRd("event flag", OffRecvFlag + 12'h008, 32'h1);
    chkRd("other flag", OffRecvFlag, 32'h0);
    chkRd("pending", OffIrqPending, 32'h04);
    `CHK("irq on", 1'b1, irq)
    wr(OffIrqEnableClr, 32'h04);
    chkRd("pending masked", OffIrqPending, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    chkRd("enable after clear", OffIrqEnableClr, 32'h0);
    wr(OffIrqEnable, 32'h04);
    chkRd("pending again", OffIrqPending, 32'h04);
    wr(OffRecvFlag + 12'h008, 32'h0);
    chkRd("flag cleared", OffRecvFlag + 12'h008, 32'h0);
    `CHK("irq off", 1'b0, irq)
  endtask : recvTask

  // write then read with no gap; the slave never stalls
  task automatic burstTask();
    @(posedge core_clk);
    req <= '{addr: OffScratch, wdata: 32'h3C5A_9617, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '{addr: OffScratch, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    `CHK("scratch burst", 32'h3C5A_9617, busRdata)
  endtask : burstTask

  // line 21 has no subscriber, so only one pulse is expected
  task automatic fabricTask();
    wr(OffSendSubscribe + 12'h004, 32'h8000_0014);
    chkRd("subscribe", OffSendSubscribe + 12'h004, 32'h8000_0014);
    wr(OffSendMask + 12'h004, 32'h80);
    @(posedge core_clk);
    fabricIn[21:20] <= 2'h3;
    @(posedge core_clk);
    fabricIn[21:20] <= 2'h0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("relayed channels", 8'h85, heard)
    `CHK("relayed cycles", 8'h02, pulseCycles)
  endtask : fabricTask

  initial begin
    #1000000;
    fails++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    regTask();
    burstTask();
    sendTask();
    recvTask();
    fabricTask();
    end_of_test();
  end
endmodule : test_interprocessor_event_channels
